// File: src/cms_top.sv
// cpu clock mode selector: config latch, mode decode, clock generation, register slave
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
module cms_top #(
  parameter int PER_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic osc_in,
  input wire logic [7:0] port0_upper_byte,
  input wire logic emulation_mode,
  input wire logic emulation_hold_mode,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_clk,
  output logic cpu_edge,
  output logic pll_enable,
  output logic [2:0] clock_mode_field
);

  cms_pll_if #(.PER_W(PER_W)) pll_bus ();

  logic [7:0] reset_config_latch;
  logic [7:0] latch_next;
  logic [15:0] reset_control_reg;
  logic [15:0] rstctl_next;
  logic [2:0] mode;
  logic emu_inv;
  logic sw_reload;

  // oscillator sampling and period measurement
  logic osc_reg;
  logic osc_rise;
  logic osc_fall;
  logic osc_any;
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_cnt_next;
  logic [PER_W-1:0] period_reg;
  logic [PER_W-1:0] period_next;
  logic per_sat;

  // cpu clock generation
  logic is_direct;
  logic is_div2;
  logic is_pll;
  logic cpu_clk_reg;
  logic cpu_clk_next;
  logic cpu_edge_reg;
  logic cpu_edge_next;
  logic [15:0] phase_cnt_reg;
  logic [15:0] phase_cnt_next;
  logic [15:0] phase_len_reg;
  logic [15:0] phase_len_next;

  // bus slave
  logic req;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic hit_latch;
  logic hit_rstctl;
  logic hit_cmd;
  logic hit_status;
  logic hit_phase;
  logic wr_rstctl;
  logic wr_cmd;
  logic [31:0] status_word;

  // ---------------- configuration latch ----------------

  assign emu_inv = emulation_mode || emulation_hold_mode;

  assign sw_reload = wr_cmd && avs_byteenable[0] && avs_writedata[cms_pkg::CMD_RELOAD_BIT];

  always_comb
  begin
    latch_next = reset_config_latch;
    if (sys_rst)
    begin
      latch_next = port0_upper_byte;
      latch_next[cms_pkg::MODE_MSB] = port0_upper_byte[cms_pkg::MODE_MSB] ^ emu_inv;
    end
    else if (sw_reload)
      latch_next = reset_control_reg[15:cms_pkg::RSTCTL_HI_LSB];
  end

  // held until the next long reset or software reload
  always_ff @(posedge mclk)
  begin
    reset_config_latch <= latch_next;
  end

  assign mode = reset_config_latch[cms_pkg::MODE_MSB:cms_pkg::MODE_LSB];

  always_comb
  begin
    rstctl_next = reset_control_reg;
    if (wr_rstctl)
    begin
      if (avs_byteenable[0])
        rstctl_next[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1])
        rstctl_next[15:8] = avs_writedata[15:8];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reset_control_reg <= cms_pkg::RSTCTL_RESET;
    else
      reset_control_reg <= rstctl_next;
  end

  // ---------------- mode decode ----------------

  assign is_direct = (mode == cms_pkg::MODE_DIRECT);
  assign is_div2 = (mode == cms_pkg::MODE_DIV2);
  assign is_pll = !is_direct && !is_div2;

  // ---------------- oscillator sampling ----------------

  assign osc_rise = osc_in && !osc_reg;
  assign osc_fall = !osc_in && osc_reg;
  assign osc_any = osc_rise || osc_fall;
  assign per_sat = &per_cnt_reg;

  always_comb
  begin
    per_cnt_next = per_sat ? per_cnt_reg : per_cnt_reg + 1'b1;
    period_next = period_reg;
    if (osc_rise)
    begin
      period_next = per_cnt_next;
      per_cnt_next = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      osc_reg <= 1'b0;
      per_cnt_reg <= '0;
      period_reg <= '0;
    end
    else
    begin
      osc_reg <= osc_in;
      per_cnt_reg <= per_cnt_next;
      period_reg <= period_next;
    end
  end

  // ---------------- pll synthesiser ----------------

  assign pll_bus.enable = is_pll;
  assign pll_bus.steps = cms_pkg::half_steps(mode);
  assign pll_bus.resync_n = cms_pkg::resync_edges(mode);
  assign pll_bus.osc_edge = osc_any;
  assign pll_bus.period = period_reg;

  cms_pll #(.PER_W(PER_W)) u_pll (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bus(pll_bus)
  );

  // ---------------- cpu clock selection ----------------

  // direct drive copies the sampled oscillator, so each pair of phases
  // spans one oscillator period whatever the duty cycle
  always_comb
  begin
    cpu_clk_next = cpu_clk_reg;
    if (is_direct)
      cpu_clk_next = osc_in;
    else if (is_div2)
    begin
      if (osc_rise)
        cpu_clk_next = !cpu_clk_reg;
    end
    else if (pll_bus.toggle)
      cpu_clk_next = !cpu_clk_reg;
  end

  assign cpu_edge_next = (cpu_clk_next != cpu_clk_reg);

  // phase length in mclk cycles, the measured clock_phase_interval
  always_comb
  begin
    phase_cnt_next = (&phase_cnt_reg) ? phase_cnt_reg : phase_cnt_reg + 16'h0001;
    phase_len_next = phase_len_reg;
    if (cpu_edge_next)
    begin
      phase_len_next = phase_cnt_next;
      phase_cnt_next = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cpu_clk_reg <= 1'b0;
      cpu_edge_reg <= 1'b0;
      phase_cnt_reg <= '0;
      phase_len_reg <= '0;
    end
    else
    begin
      cpu_clk_reg <= cpu_clk_next;
      cpu_edge_reg <= cpu_edge_next;
      phase_cnt_reg <= phase_cnt_next;
      phase_len_reg <= phase_len_next;
    end
  end

  assign cpu_clk = cpu_clk_reg;
  assign cpu_edge = cpu_edge_reg;
  assign pll_enable = is_pll && !sys_rst;
  assign clock_mode_field = mode;

  // ---------------- avalon-mm slave ----------------

  // one wait state: the read word is built while waitrequest is high
  assign req = (avs_read || avs_write) && !sys_rst;
  assign avs_waitrequest = req && !ack_reg;
  assign ack_next = req && !ack_reg;

  assign hit_latch = (avs_address == cms_pkg::ADDR_LATCH);
  assign hit_rstctl = (avs_address == cms_pkg::ADDR_RSTCTL);
  assign hit_cmd = (avs_address == cms_pkg::ADDR_CMD);
  assign hit_status = (avs_address == cms_pkg::ADDR_STATUS);
  assign hit_phase = (avs_address == cms_pkg::ADDR_PHASE);

  assign wr_rstctl = avs_write && ack_reg && hit_rstctl;
  assign wr_cmd = avs_write && ack_reg && hit_cmd;

  assign status_word = {24'h00_0000, pll_bus.locked, is_pll, cpu_clk_reg, emu_inv, 1'b0, mode};

  always_comb
  begin
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg)
    begin
      if (hit_latch)
        rdata_next = {24'h00_0000, reset_config_latch};
      else if (hit_rstctl)
        rdata_next = {16'h0000, reset_control_reg};
      else if (hit_status)
        rdata_next = status_word;
      else if (hit_phase)
        rdata_next = {16'h0000, phase_len_reg};
      else
        rdata_next = cms_pkg::RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;

endmodule

// File: src/cms_pkg.sv
// constants, register map and mode tables for the cpu clock mode select block
// What this block does
// - CPU clock mechanism chosen by three-bit mode field, latch bits 7 to 5.
// - long hardware reset loads latch from port 0 upper byte pins.
// - software may reload the latch from reset control register upper byte.
// - mode decode: 111 x4, 110 x3, 101 x2, 100 x5, 011 x1, 010 x1.5, 001 /2, 000 x2.5.
// - prescaler mode: CPU clock phase lasts exactly one oscillator period.
// - PLL modes multiply by factor, resync every factor-th transition, smoothly.
// - direct drive: PLL off, CPU clock follows oscillator and its duty cycle.
// - direct drive: two consecutive CPU phases equal one oscillator period.
// - both CPU clock edges trigger operations; edge interval is the timing unit.
// - emulation or emulation hold mode: top mode pin is taken inverted.
package cms_pkg;

  // mode field position inside the latch
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int MODE_W = 3;

  // mode codes
  localparam logic [2:0] MODE_X2P5 = 3'h0;
  localparam logic [2:0] MODE_DIV2 = 3'h1;
  localparam logic [2:0] MODE_X1P5 = 3'h2;
  localparam logic [2:0] MODE_DIRECT = 3'h3;
  localparam logic [2:0] MODE_X5 = 3'h4;
  localparam logic [2:0] MODE_X2 = 3'h5;
  localparam logic [2:0] MODE_X3 = 3'h6;
  localparam logic [2:0] MODE_X4 = 3'h7;

  // register byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_LATCH = 5'h00;
  localparam logic [4:0] ADDR_RSTCTL = 5'h04;
  localparam logic [4:0] ADDR_CMD = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_PHASE = 5'h10;

  // field positions
  localparam int CMD_RELOAD_BIT = 0;
  localparam int RSTCTL_HI_LSB = 8;
  localparam logic [15:0] RSTCTL_RESET = 16'h0000;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  localparam int HALF_W = 4;
  localparam int EDGE_W = 3;

  // cpu clock phases per oscillator period (twice the factor)
  function automatic logic [3:0] half_steps(input logic [2:0] mode);
    logic [3:0] r;
    r = 4'h8;
    case (mode)
      MODE_X4: r = 4'h8;
      MODE_X3: r = 4'h6;
      MODE_X2: r = 4'h4;
      MODE_X5: r = 4'hA;
      MODE_DIRECT: r = 4'h2;
      MODE_X1P5: r = 4'h3;
      MODE_DIV2: r = 4'h1;
      default: r = 4'h5;
    endcase
    return r;
  endfunction

  // oscillator transitions between two resync points
  function automatic logic [2:0] resync_edges(input logic [2:0] mode);
    logic [2:0] r;
    r = 3'h4;
    case (mode)
      MODE_X4: r = 3'h4;
      MODE_X3: r = 3'h3;
      MODE_X5: r = 3'h5;
      default: r = 3'h2;
    endcase
    return r;
  endfunction

endpackage

// File: src/cms_pll_if.sv
// signals between the mode selector and its pll synthesiser
`timescale 1ns/10ps
interface cms_pll_if #(parameter int PER_W = 8);
  logic enable;
  logic [cms_pkg::HALF_W-1:0] steps;
  logic [cms_pkg::EDGE_W-1:0] resync_n;
  logic osc_edge;
  logic [PER_W-1:0] period;
  logic toggle;
  logic locked;
  modport ctl (output enable, output steps, output resync_n, output osc_edge,
    output period, input toggle, input locked);
  modport pll (input enable, input steps, input resync_n, input osc_edge,
    input period, output toggle, output locked);
endinterface

// File: src/cms_pll.sv
// digital pll model: phase accumulator locked to the measured oscillator period
`timescale 1ns/10ps
module cms_pll #(
  parameter int PER_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  cms_pll_if.pll bus
);

  logic [PER_W:0] acc_reg;
  logic [PER_W:0] acc_next;
  logic [PER_W:0] acc_sum;
  logic [cms_pkg::EDGE_W-1:0] edge_cnt_reg;
  logic [cms_pkg::EDGE_W-1:0] edge_cnt_next;
  logic resync_hit;
  logic wrap_hit;
  logic late_half;
  logic toggle_reg;
  logic toggle_next;
  logic locked_reg;

  assign acc_sum = acc_reg + (PER_W+1)'(bus.steps);
  assign wrap_hit = (bus.period != '0) && (acc_sum >= {1'b0, bus.period});
  assign resync_hit = bus.osc_edge && (edge_cnt_reg + 3'h1 >= bus.resync_n);
  // at a resync an edge that is at least half due fires now, otherwise the residue is dropped
  assign late_half = ({acc_reg, 1'b0} >= {1'b0, bus.period, 1'b0} - {2'b0, bus.period});

  always_comb
  begin
    acc_next = acc_reg;
    edge_cnt_next = edge_cnt_reg;
    toggle_next = 1'b0;
    if (!bus.enable)
    begin
      acc_next = '0;
      edge_cnt_next = '0;
    end
    else if (resync_hit)
    begin
      acc_next = '0;
      edge_cnt_next = '0;
      toggle_next = wrap_hit || late_half;
    end
    else
    begin
      if (bus.osc_edge)
        edge_cnt_next = edge_cnt_reg + 3'h1;
      if (wrap_hit)
      begin
        acc_next = acc_sum - {1'b0, bus.period};
        toggle_next = 1'b1;
      end
      else
        acc_next = acc_sum;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      acc_reg <= '0;
      edge_cnt_reg <= '0;
      toggle_reg <= 1'b0;
      locked_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      edge_cnt_reg <= edge_cnt_next;
      toggle_reg <= toggle_next;
      locked_reg <= bus.enable && (bus.period != '0) && (resync_hit || locked_reg);
    end
  end

  assign bus.toggle = toggle_reg;
  assign bus.locked = locked_reg;

endmodule

// File: tb/cms_osc_model.sv
// free-running oscillator with settable high and low lengths in mclk cycles
`timescale 1ns/10ps
module cms_osc_model (
  input wire logic mclk,
  input wire logic [31:0] hi_len,
  input wire logic [31:0] lo_len,
  output logic osc_in
);
  int cnt = 0;
  initial osc_in = 1'b0;
  // uneven lengths give the duty cycle that direct drive must pass on
  always @(posedge mclk)
  begin
    if (cnt + 1 >= (osc_in ? hi_len : lo_len))
    begin
      osc_in <= !osc_in;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// File: tb/cms_top_chk.sv
// port assertions for the cpu clock mode selector
`timescale 1ns/10ps
module cms_top_chk #(
  parameter int PER_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic osc_in,
  input wire logic [7:0] port0_upper_byte,
  input wire logic emulation_mode,
  input wire logic emulation_hold_mode,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cpu_clk,
  input wire logic cpu_edge,
  input wire logic pll_enable,
  input wire logic [2:0] clock_mode_field
);
  wire cmd_go = avs_write && !avs_waitrequest && avs_address == cms_pkg::ADDR_CMD &&
    avs_byteenable[0] && avs_writedata[0];
  wire is_dir = clock_mode_field == cms_pkg::MODE_DIRECT;
  wire is_div = clock_mode_field == cms_pkg::MODE_DIV2;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wait_one_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not after one wait");
  pll_map_a: assert property (pll_enable == !(is_dir || is_div))
    else $error("pll enable wrong for mode");
  edge_pulse_a: assert property (!$past(sys_rst) |-> cpu_edge == $changed(cpu_clk))
    else $error("edge pulse not tied to clock change");
  direct_follow_a: assert property (!$past(sys_rst) && is_dir && $stable(is_dir) |->
    cpu_clk == $past(osc_in)) else $error("direct clock not following oscillator");
  div_toggle_a: assert property (!$past(sys_rst) && is_div && $rose(osc_in) |=>
    $changed(cpu_clk)) else $error("prescaler missed a toggle");
  div_hold_a: assert property (!$past(sys_rst) && is_div && !$rose(osc_in) |=>
    $stable(cpu_clk)) else $error("prescaler toggled without cause");
  mode_hold_a: assert property ($changed(clock_mode_field) |->
    $past(sys_rst) || $past(cmd_go) || $past(cmd_go, 2)) else $error("mode changed by itself");
  capture_a: assert property ($fell(sys_rst) |-> clock_mode_field ==
    {$past(port0_upper_byte[7] ^ (emulation_mode | emulation_hold_mode)),
    $past(port0_upper_byte[6:5])}) else $error("mode not captured from pins");
endmodule
bind cms_top cms_top_chk #(.PER_W(PER_W)) u_cms_top_chk (.mclk(mclk), .sys_rst(sys_rst),
  .osc_in(osc_in), .port0_upper_byte(port0_upper_byte), .emulation_mode(emulation_mode),
  .emulation_hold_mode(emulation_hold_mode), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge),
  .pll_enable(pll_enable), .clock_mode_field(clock_mode_field));

// File: tb/tb_cms_top.sv
// self-checking bench for the cpu clock mode selector
`timescale 1ns/10ps
module tb_cms_top;
  logic mclk = 0, sys_rst = 1, emulation_mode = 0, emulation_hold_mode = 0, avs_read = 0;
  logic avs_write = 0, avs_waitrequest, cpu_clk, cpu_edge, pll_enable, osc_in;
  logic [7:0] port0_upper_byte = 8'hFF;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic [2:0] clock_mode_field;
  int hi_len = 20, lo_len = 20, error_cnt = 0, num_checks = 0;
  int exp2f [8] = '{5, 1, 3, 2, 10, 4, 6, 8};
  cms_top u_cms_top (.mclk(mclk), .sys_rst(sys_rst), .osc_in(osc_in),
    .port0_upper_byte(port0_upper_byte), .emulation_mode(emulation_mode),
    .emulation_hold_mode(emulation_hold_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge),
    .pll_enable(pll_enable), .clock_mode_field(clock_mode_field));
  cms_osc_model u_cms_osc_model (.mclk(mclk), .hi_len(hi_len), .lo_len(lo_len),
    .osc_in(osc_in));
  initial
  begin
    forever #12.5 mclk = !mclk;
  end
  task test_done;
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_near(input int g, input int e, input int t);
    num_checks++;
    if (g < e - t || g > e + t)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; data taken and
  // request dropped at that same edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    if (n == 20)
      error_cnt++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task do_rst(input logic [7:0] p, input logic em, input logic eh);
    @(posedge mclk);
    sys_rst <= 1'b1;
    port0_upper_byte <= p;
    emulation_mode <= em;
    emulation_hold_mode <= eh;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask
  task t_capture;
    logic [31:0] q;
    do_rst(8'h5F, 1'b0, 1'b0);
    bus(1'b0, cms_pkg::ADDR_LATCH, 32'h0, 4'h0, q);
    chk(q, 32'h5F);
    do_rst(8'h7F, 1'b1, 1'b0);
    bus(1'b0, cms_pkg::ADDR_STATUS, 32'h0, 4'h0, q);
    chk(q & 32'h5F, 32'h57);
    do_rst(8'h7F, 1'b0, 1'b1);
    bus(1'b0, cms_pkg::ADDR_LATCH, 32'h0, 4'h0, q);
    chk(q, 32'hFF);
  endtask
  task t_regs;
    logic [31:0] q;
    bus(1'b0, cms_pkg::ADDR_RSTCTL, 32'h0, 4'h0, q);
    chk(q, 32'h0);
    bus(1'b1, cms_pkg::ADDR_RSTCTL, 32'h12345678, 4'hF, q);
    bus(1'b1, cms_pkg::ADDR_LATCH, 32'h0, 4'hF, q);
    bus(1'b1, 5'h14, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b0, 5'h14, 32'h0, 4'h0, q);
    chk(q, 32'h0);
    bus(1'b0, cms_pkg::ADDR_RSTCTL, 32'h0, 4'h0, q);
    chk(q, 32'h5678);
    // lane 0 off: the command must not reload
    bus(1'b1, cms_pkg::ADDR_CMD, 32'h1, 4'h2, q);
    bus(1'b0, cms_pkg::ADDR_LATCH, 32'h0, 4'h0, q);
    chk(q, 32'hFF);
    bus(1'b1, cms_pkg::ADDR_CMD, 32'h1, 4'h1, q);
    bus(1'b0, cms_pkg::ADDR_LATCH, 32'h0, 4'h0, q);
    chk(q, 32'h56);
  endtask
  task t_modes;
    logic [31:0] q;
    int n;
    for (int m = 0; m < 8; m++)
    begin
      bus(1'b1, cms_pkg::ADDR_RSTCTL, {16'h0, 3'(m), 5'h05, 8'hA5}, 4'h3, q);
      bus(1'b1, cms_pkg::ADDR_CMD, 32'h1, 4'h1, q);
      // pll needs a measured period before its rate is meaningful
      repeat (120) @(posedge mclk);
      chk(32'(clock_mode_field), 32'(m));
      chk(32'(pll_enable), 32'(m != 3 && m != 1));
      n = 0;
      @(posedge osc_in);
      repeat (160) @(negedge mclk) if (cpu_edge === 1'b1) n++;
      chk_near(n, 4 * exp2f[m], 2);
      bus(1'b0, cms_pkg::ADDR_LATCH, 32'h0, 4'h0, q);
      chk(q, {24'h0, 3'(m), 5'h05});
    end
  endtask
  task t_duty;
    logic [31:0] q;
    int h, l;
    @(posedge mclk);
    hi_len <= 10;
    lo_len <= 30;
    bus(1'b1, cms_pkg::ADDR_RSTCTL, 32'h7FA5, 4'h3, q);
    bus(1'b1, cms_pkg::ADDR_CMD, 32'h1, 4'h1, q);
    repeat (100) @(posedge mclk);
    @(posedge cpu_clk);
    h = 0;
    l = 0;
    @(negedge mclk);
    while (cpu_clk === 1'b1 && h < 99)
    begin
      h++;
      @(negedge mclk);
    end
    while (cpu_clk === 1'b0 && l < 99)
    begin
      l++;
      @(negedge mclk);
    end
    chk_near(h, 10, 0);
    chk_near(h + l, 40, 0);
    // read lands inside the short high phase, so the low phase is the last one done
    bus(1'b0, cms_pkg::ADDR_PHASE, 32'h0, 4'h0, q);
    chk(q, 32'(lo_len));
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_capture;
    t_regs;
    t_modes;
    t_duty;
    test_done;
  end
  initial
  begin
    #500000;
    error_cnt++;
    test_done;
  end
endmodule
